// ---- design/ubpc_pkg.sv ----
// Package with register map, field layout, reset values and timing constants of the block.
package ubpc_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_UB_DLY = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ECHO_DLY = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

    // ****************************************************************
    // Scheme selection.
    // ****************************************************************
    typedef enum logic [1:0] {
        SCHEME_OFF = 2'b00,
        SCHEME_POTT = 2'b01,
        SCHEME_UNBLOCK_TWO_TERMINAL = 2'b10,
        SCHEME_UNBLOCK_THREE_TERMINAL = 2'b11
    } ubpc_scheme_e;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int DLY_W = 8;
    localparam int CTRL_SCHEME_LSB = 0;
    localparam int CTRL_ZONE_EN_LSB = 2;
    localparam int CTRL_PUTT_BIT = 6;
    localparam int CTRL_PUTT_ECHO_BIT = 7;
    localparam int UB_DECLARE_LSB = 0;
    localparam int UB_DISABLE_LSB = 8;
    localparam int UB_GUARD_LSB = 16;
    localparam int ECHO_PICKUP_LSB = 0;
    localparam int ECHO_DURATION_LSB = 8;

    // ****************************************************************
    // Reset values, delays in half power-system cycles.
    // ****************************************************************
    localparam logic [31:0] CTRL_RESET = 32'h0000_003c;
    localparam logic [31:0] UB_DLY_RESET = 32'h0014_1201;
    localparam logic [31:0] ECHO_DLY_RESET = 32'h0000_0804;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int HALF_CYCLE_NS = 8333333;
    localparam int TICK_CYCLES = HALF_CYCLE_NS / CLK_PERIOD_NS;

endpackage

// ---- design/ubpc_pickup_timer.sv ----
// Pickup timer that counts half-cycle ticks while its input stands.
`timescale 1ns/1ps
module ubpc_pickup_timer
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic [ubpc_pkg::DLY_W-1:0] delay_in,
    output logic expired_out
);
    import ubpc_pkg::*;

    logic [DLY_W-1:0] cnt_ff;
    logic [DLY_W-1:0] nxt_cnt;
    wire at_max = (cnt_ff == {DLY_W{1'b1}});

    // The count restarts whenever the input drops and saturates at full scale.
    assign nxt_cnt = !start_in ? '0 : ((tick_in && !at_max) ? cnt_ff + 1'b1 : cnt_ff);
    assign expired_out = start_in && (cnt_ff >= delay_in);

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // ubpc_pickup_timer

// ---- design/ubpc_unblock_logic.sv ----
// Unblocking permissive channel logic with APB settings and transmit keying.
// Overview of operation
// - Unblocking runs only in unblocking scheme choices.
// - Permissive overreaching logic also runs when unblocking.
// - Two-terminal choice uses channel one only.
// - Three-terminal choice runs channels one and two.
// - Each channel maps guard loss, permissive to outputs.
// - Received permissives merge by mode for echo.
// - Guard must stand pickup time before reinstating.
// - Each channel owns timers sharing common delays.
// - Lasting channel loss stops permissive tripping.
// - Channel loss declared after minimum persist time.
// - Two-terminal: channel one block after disable time.
// - Three-terminal: each channel blocks independently.
// - Channel blocks merge; combined block inhibits trips.
// - Two-terminal receive on loss or permissive.
// - Three-terminal receive per channel likewise.
// - Channel receives merge by mode for trip.
// - Echo key output shows echoed permissive.
// - Underreaching key ORs enabled zone one elements.
// - Underreaching key optionally adds echo key.
// - Second transmit output equals the first.
// - Key on trip equation unless reversal guard.
// - Echo starts after pickup; zero disables echo.
// - Echo duration limited to avoid lockup.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ubpc_unblock_logic
#(
    parameter int TICK_CYCLES = ubpc_pkg::TICK_CYCLES
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ubpc_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic guard_lost_ch1_in,
    input wire logic guard_lost_ch2_in,
    input wire logic permissive_in_ch1_in,
    input wire logic permissive_in_ch2_in,
    input wire logic comm_assisted_trip_equation_in,
    input wire logic current_reversal_guard_in,
    input wire logic zone1_phase_distance_in,
    input wire logic zone1_ground_distance_in,
    input wire logic zone1_residual_directional_in,
    input wire logic zone1_negseq_directional_in,
    output logic permit_receive_ch1_out,
    output logic permit_receive_ch2_out,
    output logic permit_receive_combined_out,
    output logic unblock_block_ch1_out,
    output logic unblock_block_ch2_out,
    output logic unblock_block_combined_out,
    output logic permissive_combined_out,
    output logic echo_key_out,
    output logic transmit_output_a_out,
    output logic transmit_output_b_out
);
    import ubpc_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    // ****************************************************************
    // Register bus.
    // ****************************************************************
    logic [31:0] ctrl_ff;
    logic [31:0] ub_dly_ff;
    logic [31:0] echo_dly_ff;
    logic [31:0] rdata_ff;
    logic [31:0] status_word;
    wire sel_ctrl = (paddr_in == ADDR_CTRL);
    wire sel_ub = (paddr_in == ADDR_UB_DLY);
    wire sel_echo = (paddr_in == ADDR_ECHO_DLY);
    wire sel_status = (paddr_in == ADDR_STATUS);
    wire addr_ok = sel_ctrl || sel_ub || sel_echo || sel_status;
    wire setup_phase = psel_in && !penable_in;
    wire access_phase = psel_in && penable_in;
    wire wr_en = access_phase && pwrite_in;
    wire [31:0] rd_mux = sel_ctrl ? ctrl_ff :
                         sel_ub ? ub_dly_ff :
                         sel_echo ? echo_dly_ff :
                         sel_status ? status_word : 32'h0000_0000;

    assign pready_out = access_phase;
    assign pslverr_out = access_phase && !addr_ok;
    assign prdata_out = rdata_ff;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_ff <= CTRL_RESET;
            ub_dly_ff <= UB_DLY_RESET;
            echo_dly_ff <= ECHO_DLY_RESET;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            if (wr_en && sel_ctrl)
                ctrl_ff <= pwdata_in;
            if (wr_en && sel_ub)
                ub_dly_ff <= pwdata_in;
            if (wr_en && sel_echo)
                echo_dly_ff <= pwdata_in;
            if (setup_phase)
                rdata_ff <= rd_mux;
        end
    end

    // ****************************************************************
    // Settings decode.
    // ****************************************************************
    ubpc_scheme_e scheme;
    assign scheme = ubpc_scheme_e'(ctrl_ff[CTRL_SCHEME_LSB +: 2]);
    wire [3:0] zone_en = ctrl_ff[CTRL_ZONE_EN_LSB +: 4];
    wire putt_en = ctrl_ff[CTRL_PUTT_BIT];
    wire putt_echo_en = ctrl_ff[CTRL_PUTT_ECHO_BIT];
    wire [DLY_W-1:0] declare_dly = ub_dly_ff[UB_DECLARE_LSB +: DLY_W];
    wire [DLY_W-1:0] disable_dly = ub_dly_ff[UB_DISABLE_LSB +: DLY_W];
    wire [DLY_W-1:0] guard_dly = ub_dly_ff[UB_GUARD_LSB +: DLY_W];
    wire [DLY_W-1:0] echo_pu_dly = echo_dly_ff[ECHO_PICKUP_LSB +: DLY_W];
    wire [DLY_W-1:0] echo_dur_dly = echo_dly_ff[ECHO_DURATION_LSB +: DLY_W];
    wire is_two = (scheme == SCHEME_UNBLOCK_TWO_TERMINAL);
    wire is_three = (scheme == SCHEME_UNBLOCK_THREE_TERMINAL);
    wire ub_active = is_two || is_three;
    wire pott_active = ub_active || (scheme == SCHEME_POTT);
    wire [1:0] ch_active = {is_three, ub_active};

    // ****************************************************************
    // Pin synchronisers and half-cycle tick.
    // ****************************************************************
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [TW-1:0] tick_cnt_ff;
    wire tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            tick_cnt_ff <= '0;
        end
        else
        begin
            sync1_ff <= {permissive_in_ch2_in, permissive_in_ch1_in,
                         guard_lost_ch2_in, guard_lost_ch1_in};
            sync2_ff <= sync1_ff;
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
        end
    end

    wire [1:0] ch_guard_lost = sync2_ff[1:0];
    wire [1:0] ch_pt = sync2_ff[3:2];

    // ****************************************************************
    // Per-channel unblocking logic.
    // ****************************************************************
    logic [1:0] loc;
    logic [1:0] ubb_tmr;
    logic [1:0] guard_ok;
    logic [1:0] hold_ff;
    logic [1:0] ch_ubb;
    logic [1:0] ch_prx;

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        wire loss_raw = ch_active[c] && ch_guard_lost[c];
        wire guard_raw = ch_active[c] && !ch_guard_lost[c];

        ubpc_pickup_timer u_declare
        (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .tick_in(tick),
            .start_in(loss_raw),
            .delay_in(declare_dly),
            .expired_out(loc[c])
        );

        ubpc_pickup_timer u_disable
        (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .tick_in(tick),
            .start_in(loc[c]),
            .delay_in(disable_dly),
            .expired_out(ubb_tmr[c])
        );

        ubpc_pickup_timer u_guard
        (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .tick_in(tick),
            .start_in(guard_raw),
            .delay_in(guard_dly),
            .expired_out(guard_ok[c])
        );

        // The block holds after a long loss until guard has stood its delay.
        always_ff @(posedge clk_in or negedge nrst_in)
        begin
            if (!nrst_in)
                hold_ff[c] <= 1'b0;
            else if (!ch_active[c])
                hold_ff[c] <= 1'b0;
            else if (ubb_tmr[c])
                hold_ff[c] <= 1'b1;
            else if (guard_ok[c])
                hold_ff[c] <= 1'b0;
        end

        assign ch_ubb[c] = ch_active[c] && (ubb_tmr[c] || hold_ff[c]);
        assign ch_prx[c] = ch_active[c] && !ch_ubb[c] && (loc[c] || ch_pt[c]);
    end

    // ****************************************************************
    // Mode merge.
    // ****************************************************************
    wire nxt_pt_comb = is_three ? (ch_pt[0] && ch_pt[1]) :
                       pott_active ? ch_pt[0] : 1'b0;
    wire nxt_prx_comb = is_three ? (ch_prx[0] && ch_prx[1]) :
                        is_two ? ch_prx[0] :
                        pott_active ? ch_pt[0] : 1'b0;
    wire nxt_ubb_comb = is_three ? (ch_ubb[0] || ch_ubb[1]) :
                        is_two ? ch_ubb[0] : 1'b0;

    // ****************************************************************
    // Echo and keying.
    // ****************************************************************
    logic echo_pu;
    logic echo_over;
    wire echo_on = pott_active && (echo_pu_dly != '0);

    ubpc_pickup_timer u_echo_pu
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick),
        .start_in(echo_on && nxt_pt_comb),
        .delay_in(echo_pu_dly),
        .expired_out(echo_pu)
    );

    ubpc_pickup_timer u_echo_dur
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick),
        .start_in(echo_pu),
        .delay_in(echo_dur_dly),
        .expired_out(echo_over)
    );

    wire nxt_echo = echo_pu && !echo_over;
    wire zone1_any = |(zone_en & {zone1_negseq_directional_in, zone1_residual_directional_in,
                                  zone1_ground_distance_in, zone1_phase_distance_in});
    wire key_putt = zone1_any || (putt_echo_en && nxt_echo);
    wire key_pott = pott_active && !current_reversal_guard_in
                    && (comm_assisted_trip_equation_in || nxt_echo);
    wire nxt_tx = putt_en ? key_putt : key_pott;

    // ****************************************************************
    // Output registers.
    // ****************************************************************
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            permit_receive_ch1_out <= 1'b0;
            permit_receive_ch2_out <= 1'b0;
            permit_receive_combined_out <= 1'b0;
            unblock_block_ch1_out <= 1'b0;
            unblock_block_ch2_out <= 1'b0;
            unblock_block_combined_out <= 1'b0;
            permissive_combined_out <= 1'b0;
            echo_key_out <= 1'b0;
            transmit_output_a_out <= 1'b0;
            transmit_output_b_out <= 1'b0;
        end
        else
        begin
            permit_receive_ch1_out <= ch_prx[0];
            permit_receive_ch2_out <= ch_prx[1];
            permit_receive_combined_out <= nxt_prx_comb;
            unblock_block_ch1_out <= ch_ubb[0];
            unblock_block_ch2_out <= ch_ubb[1];
            unblock_block_combined_out <= nxt_ubb_comb;
            permissive_combined_out <= nxt_pt_comb;
            echo_key_out <= nxt_echo;
            transmit_output_a_out <= nxt_tx;
            transmit_output_b_out <= nxt_tx;
        end
    end

    assign status_word = {19'h0, hold_ff, loc, transmit_output_a_out, echo_key_out,
                          permissive_combined_out, unblock_block_combined_out,
                          unblock_block_ch2_out, unblock_block_ch1_out,
                          permit_receive_combined_out, permit_receive_ch2_out,
                          permit_receive_ch1_out};

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_mode_gate_off: assert property (!ub_active |=> !unblock_block_combined_out)
        else $error("Unblock block set outside unblocking scheme.");
    a_pott_key_runs: assert property (ub_active && !putt_en && comm_assisted_trip_equation_in
        && !current_reversal_guard_in |=> transmit_output_a_out)
        else $error("Trip equation did not key in unblocking scheme.");
    a_ch2_idle_two: assert property (is_two |=> !permit_receive_ch2_out
        && !unblock_block_ch2_out)
        else $error("Channel two active in two-terminal scheme.");
    a_loc_needs_guard: assert property (loc[1] |-> is_three && ch_guard_lost[1])
        else $error("Channel two loss outside three-terminal scheme.");
    a_loc_declare: assert property (loc[0] |-> ch_guard_lost[0] && ub_active)
        else $error("Loss of channel without guard loss.");
    a_ubb_disable: assert property (ubb_tmr[0] && ub_active |=> unblock_block_ch1_out)
        else $error("Channel one block missing after disable time.");
    a_ubb_each_ch: assert property (ubb_tmr[1] && is_three |=> unblock_block_ch2_out
        && unblock_block_combined_out)
        else $error("Channel two block not routed.");
    a_block_no_rx: assert property (unblock_block_combined_out |-> !permit_receive_combined_out)
        else $error("Permissive receive while blocked.");
    a_prx_cause: assert property (permit_receive_ch1_out |-> $past(loc[0] || ch_pt[0]))
        else $error("Channel one receive without cause.");
    a_tx_mirror: assert property (transmit_output_a_out == transmit_output_b_out)
        else $error("Transmit outputs differ.");
    a_key_reversal: assert property (current_reversal_guard_in && !putt_en
        |=> !transmit_output_a_out)
        else $error("Key sent during current reversal.");
    a_echo_off: assert property (echo_pu_dly == '0 ##1 echo_pu_dly == '0
        |-> !echo_key_out)
        else $error("Echo with pickup set off.");
    a_putt_zone: assert property (putt_en && zone_en[0] && zone1_phase_distance_in
        |=> transmit_output_a_out)
        else $error("Zone one element did not key.");
    a_apb_write: assert property (wr_en && sel_ctrl |=> ctrl_ff == $past(pwdata_in))
        else $error("Control write did not land.");

    c_block_rise: cover property ($rose(unblock_block_combined_out));
    c_echo_rise: cover property ($rose(echo_key_out));
    c_rx_three: cover property (is_three && $rose(permit_receive_combined_out));
    c_apb_write: cover property (wr_en && sel_ub);
endmodule // ubpc_unblock_logic

// ---- testbench/ubpc_rx_model.sv ----
// Receiver model that drives the loss-of-guard and permissive pins of two remote ends.
`timescale 1ns/1ps
module ubpc_rx_model
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic slow_in,
    input wire logic [1:0] lose_guard_in,
    input wire logic [1:0] send_permit_in,
    output logic [1:0] guard_lost_out,
    output logic [1:0] permissive_out
);
    logic [3:0] stage_ff;
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            stage_ff <= 4'h0;
            guard_lost_out <= 2'h0;
            permissive_out <= 2'h0;
        end
        else
        begin
            stage_ff <= {lose_guard_in, send_permit_in};
            guard_lost_out <= slow_in ? stage_ff[3:2] : lose_guard_in;
            permissive_out <= slow_in ? stage_ff[1:0] : send_permit_in;
        end
    end
endmodule // ubpc_rx_model

// ---- testbench/unblocking_permissive_channel_logic_bench.sv ----
// Self-checking bench for the unblocking permissive channel logic.
`timescale 1ns/1ps
module unblocking_permissive_channel_logic_bench;
    import ubpc_pkg::*;
    typedef struct packed {logic [7:0] ctrl; logic [3:0] zone; logic trip, rev, tx;} ubpc_row_s;
    localparam ubpc_row_s ROWS [8] = '{'{8'h7c, 4'h1, 1'b0, 1'b0, 1'b1},
        '{8'h7c, 4'h2, 1'b0, 1'b0, 1'b1}, '{8'h7c, 4'h4, 1'b0, 1'b0, 1'b1},
        '{8'h7c, 4'h8, 1'b0, 1'b0, 1'b1}, '{8'h44, 4'he, 1'b0, 1'b0, 1'b0},
        '{8'h01, 4'h0, 1'b1, 1'b0, 1'b1}, '{8'h01, 4'h0, 1'b1, 1'b1, 1'b0},
        '{8'h00, 4'h0, 1'b1, 1'b0, 1'b0}};
    localparam logic [7:0] REG_ADDR [3] = '{ADDR_CTRL, ADDR_UB_DLY, ADDR_ECHO_DLY};
    localparam logic [31:0] REG_INIT [3] = '{CTRL_RESET, UB_DLY_RESET, ECHO_DLY_RESET};
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic trip = 1'b0;
    logic rev = 1'b0;
    logic slow = 1'b0;
    logic [3:0] zone = 4'h0;
    logic [1:0] lose = 2'h0;
    logic [1:0] permit = 2'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [1:0] pin_guard, pin_permit;
    logic prx1, prx2, prxc, unblock_block_ch1, unblock_block_ch2, ubbc, ptc, echo, tx_a, tx_b;
    logic [9:0] outs;
    int err_count = 0;
    int num_checks = 0;
    int n;
    assign outs = {prx1, prx2, prxc, unblock_block_ch1, unblock_block_ch2, ubbc, ptc, echo, tx_a, tx_b};
    always #12.5 clk_in = ~clk_in;

    ubpc_unblock_logic #(.TICK_CYCLES(4)) DUT
    (
        .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .guard_lost_ch1_in(pin_guard[0]), .guard_lost_ch2_in(pin_guard[1]),
        .permissive_in_ch1_in(pin_permit[0]), .permissive_in_ch2_in(pin_permit[1]),
        .comm_assisted_trip_equation_in(trip), .current_reversal_guard_in(rev),
        .zone1_phase_distance_in(zone[0]), .zone1_ground_distance_in(zone[1]),
        .zone1_residual_directional_in(zone[2]), .zone1_negseq_directional_in(zone[3]),
        .permit_receive_ch1_out(prx1), .permit_receive_ch2_out(prx2),
        .permit_receive_combined_out(prxc), .unblock_block_ch1_out(unblock_block_ch1),
        .unblock_block_ch2_out(unblock_block_ch2), .unblock_block_combined_out(ubbc),
        .permissive_combined_out(ptc), .echo_key_out(echo),
        .transmit_output_a_out(tx_a), .transmit_output_b_out(tx_b)
    );

    ubpc_rx_model RX
    (
        .clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow), .lose_guard_in(lose),
        .send_permit_in(permit), .guard_lost_out(pin_guard), .permissive_out(pin_permit)
    );

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_bit(input string what, input logic seen, input logic exp);
        check(what, 32'(seen), 32'(exp));
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_in);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        check_bit("pready", pready, 1'b1);
        if (pready !== 1'b1)
            report_and_stop();
        else
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_in);
        end
    endtask

    task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
        n = 0;
        while (sig !== lvl)
        begin
            if (n == lim)
            begin
                check_bit("wait limit", sig, lvl);
                report_and_stop();
            end
            @(posedge clk_in);
            n++;
        end
    endtask

    // ****************************************************************
    // Sequence.
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge clk_in);
        check("outs in reset", 32'(outs), 32'h0);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, REG_ADDR[i], 32'h0);
            check("reset value", rd, REG_INIT[i]);
        end
        apb(1'b0, 8'h10, 32'h0);
        check_bit("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        $display("test registers done");
        foreach (ROWS[i])
        begin
            apb(1'b1, ADDR_CTRL, {24'h0, ROWS[i].ctrl});
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("ctrl readback", rd, {24'h0, ROWS[i].ctrl});
            zone <= ROWS[i].zone;
            trip <= ROWS[i].trip;
            rev <= ROWS[i].rev;
            repeat (4) @(posedge clk_in);
            check_bit("tx a", tx_a, ROWS[i].tx);
            check_bit("tx b", tx_b, ROWS[i].tx);
        end
        zone <= 4'h0;
        trip <= 1'b0;
        $display("test rows done");
        apb(1'b1, ADDR_UB_DLY, 32'h0004_0401);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        lose <= 2'b11;
        wait_lvl(prx1, 1'b1, 60);
        check_bit("receive on loss", unblock_block_ch1, 1'b0);
        wait_lvl(unblock_block_ch1, 1'b1, 60);
        check_bit("disable span", n >= 10 && n <= 24, 1'b1);
        check_bit("receive gated", prx1, 1'b0);
        check_bit("block comb", ubbc, 1'b1);
        check_bit("ch2 unused", unblock_block_ch2, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status blocked", rd, 32'h0000_0a28);
        lose <= 2'b00;
        repeat (8) @(posedge clk_in);
        check_bit("guard hold", unblock_block_ch1, 1'b1);
        wait_lvl(unblock_block_ch1, 1'b0, 60);
        permit <= 2'b01;
        repeat (8) @(posedge clk_in);
        check_bit("receive on permit", prx1, 1'b1);
        permit <= 2'b00;
        $display("test two terminal done");
        slow <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        lose <= 2'b10;
        wait_lvl(unblock_block_ch2, 1'b1, 80);
        check_bit("ch1 free", unblock_block_ch1, 1'b0);
        check_bit("block or", ubbc, 1'b1);
        lose <= 2'b00;
        wait_lvl(unblock_block_ch2, 1'b0, 90);
        permit <= 2'b01;
        repeat (8) @(posedge clk_in);
        check_bit("prx1 alone", prx1, 1'b1);
        check_bit("prx and", prxc, 1'b0);
        check_bit("pt and", ptc, 1'b0);
        permit <= 2'b11;
        repeat (8) @(posedge clk_in);
        check_bit("prx2", prx2, 1'b1);
        check_bit("prx both", prxc, 1'b1);
        check_bit("pt both", ptc, 1'b1);
        permit <= 2'b00;
        $display("test three terminal done");
        slow <= 1'b0;
        apb(1'b1, ADDR_ECHO_DLY, 32'h0000_0201);
        apb(1'b1, ADDR_CTRL, 32'h0000_00c1);
        permit <= 2'b01;
        wait_lvl(echo, 1'b1, 60);
        repeat (2) @(posedge clk_in);
        check_bit("echo held", echo, 1'b1);
        check_bit("echo in key", tx_a, 1'b1);
        wait_lvl(echo, 1'b0, 40);
        permit <= 2'b00;
        apb(1'b1, ADDR_ECHO_DLY, 32'h0000_0200);
        lose <= 2'b01;
        repeat (4) @(posedge clk_in);
        permit <= 2'b01;
        repeat (40) @(posedge clk_in);
        check_bit("echo off", echo, 1'b0);
        check_bit("no unblock in pott", unblock_block_ch1, 1'b0);
        check_bit("pott receive", prxc, 1'b1);
        $display("test echo done");
        nrst_in <= 1'b0;
        @(posedge clk_in);
        check("outs in reset", 32'(outs), 32'h0);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        apb(1'b0, ADDR_ECHO_DLY, 32'h0);
        check("echo reg reset", rd, ECHO_DLY_RESET);
        $display("test reset done");
        report_and_stop();
    end
endmodule // unblocking_permissive_channel_logic_bench
